// ---- src/tmc_timer_ctrl.sv ----
/*
  Timer control register, external interrupt flags and the third
  16-bit timer with capture, auto-reload and baud generator modes.
  Assumes a byte-wide special function bus from the core, with
  interrupt service acknowledges and basic timer overflow pulses
  supplied by neighbouring logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_timer_ctrl
  import tmc_pkg::*;
(
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RSTN,
  // Special function register access
  input  wire logic [7:0] I_SFR_ADDR,
  input  wire logic       I_SFR_WR,
  input  wire logic [7:0] I_SFR_WDATA,
  output logic      [7:0] O_SFR_RDATA,
  // Interrupt service acknowledges
  input  wire logic       I_ACK_OVF_ONE,
  input  wire logic       I_ACK_OVF_ZERO,
  input  wire logic       I_ACK_IRQ_ONE,
  input  wire logic       I_ACK_IRQ_ZERO,
  // Basic timer links
  input  wire logic       I_T0_OVF,
  input  wire logic       I_T1_OVF,
  input  wire logic       I_GATE_ZERO,
  input  wire logic       I_GATE_ONE,
  output logic            O_T0_COUNT_EN,
  output logic            O_T1_COUNT_EN,
  // External pins
  input  wire logic       I_EVENT_PIN,
  input  wire logic       I_TRIGGER_PIN,
  input  wire logic       I_IRQ_PIN_ZERO,
  input  wire logic       I_IRQ_PIN_ONE,
  // Interrupt requests
  output logic            O_OVF_FLAG_ZERO,
  output logic            O_OVF_FLAG_ONE,
  output logic            O_IRQ_FLAG_ZERO,
  output logic            O_IRQ_FLAG_ONE,
  output logic            O_THIRD_IRQ,
  // Serial port baud pulses
  output logic            O_RX_BAUD_PULSE,
  output logic            O_TX_BAUD_PULSE
);

  tmc_smp_if smp ();

  tmc_pin_sampler #(
    .NUM_PINS (`TMC_NUM_PINS)
  ) u_sampler (
    .i_clk  (I_CLK),
    .i_rstn (I_RSTN),
    .i_pins ({I_IRQ_PIN_ONE, I_IRQ_PIN_ZERO, I_TRIGGER_PIN, I_EVENT_PIN}),
    .smp    (smp)
  );

  // Timer control register fields
  logic        ovf_flag_one_reg;
  logic        run_bit_one_reg;
  logic        ovf_flag_zero_reg;
  logic        run_bit_zero_reg;
  logic        ext_irq_flag_one_reg;
  logic        ext_irq_type_one_reg;
  logic        ext_irq_flag_zero_reg;
  logic        ext_irq_type_zero_reg;

  // Third timer control fields
  logic        third_overflow_flag_reg;
  logic        third_external_flag_reg;
  logic        receive_clock_select_reg;
  logic        transmit_clock_select_reg;
  logic        external_trigger_enable_reg;
  logic        third_run_bit_reg;
  logic        count_source_select_reg;
  logic        capture_reload_select_reg;

  // Third timer data
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] capture_reload_reg;
  logic [7:0]  rdata_reg;

  // Decoded strobes and events
  logic         wr_timer_control;
  logic         wr_third_timer_control;
  logic         wr_low;
  logic         wr_high;
  logic         wr_cap_low;
  logic         wr_cap_high;
  tmc_mode_type mode;
  logic         count_tick;
  logic         overflow;
  logic         trigger_event;
  logic         third_baud_pulse;
  logic         irq_set_zero;
  logic         irq_set_one;

  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = I_SFR_WR && (addr == target);
  endfunction

  // Baud generation outranks the capture/reload choice
  function automatic tmc_mode_type decode_mode(input logic run,
                                               input logic rclk,
                                               input logic transmit_clock_select,
                                               input logic cap);
    if (!run) begin
      decode_mode = TMC_MODE_OFF;
    end else if (rclk || transmit_clock_select) begin
      decode_mode = TMC_MODE_BAUD;
    end else if (cap) begin
      decode_mode = TMC_MODE_CAPTURE;
    end else begin
      decode_mode = TMC_MODE_RELOAD;
    end
  endfunction

  // Level or falling edge detection of one external interrupt pin
  function automatic logic irq_detect(input logic edge_type,
                                      input logic pin_level,
                                      input logic pin_fall);
    irq_detect = edge_type ? pin_fall : ~pin_level;
  endfunction

  assign wr_timer_control     = addr_hit(I_SFR_ADDR, `TMC_ADDR_TIMER_CONTROL);
  assign wr_third_timer_control    = addr_hit(I_SFR_ADDR, `TMC_ADDR_THIRD_CONTROL);
  assign wr_low      = addr_hit(I_SFR_ADDR, `TMC_ADDR_COUNT_LOW);
  assign wr_high     = addr_hit(I_SFR_ADDR, `TMC_ADDR_COUNT_HIGH);
  assign wr_cap_low  = addr_hit(I_SFR_ADDR, `TMC_ADDR_CAPRLD_LOW);
  assign wr_cap_high = addr_hit(I_SFR_ADDR, `TMC_ADDR_CAPRLD_HIGH);

  assign mode = decode_mode(third_run_bit_reg, receive_clock_select_reg,
                            transmit_clock_select_reg,
                            capture_reload_select_reg);

  // Basic timer enables honour run bit and gate
  assign O_T0_COUNT_EN = run_bit_zero_reg &&
                         (!I_GATE_ZERO ||
                          smp.level[`TMC_PIN_IRQ_ZERO]);
  assign O_T1_COUNT_EN = run_bit_one_reg &&
                         (!I_GATE_ONE ||
                          smp.level[`TMC_PIN_IRQ_ONE]);

  assign irq_set_zero = irq_detect(ext_irq_type_zero_reg,
                                   smp.level[`TMC_PIN_IRQ_ZERO],
                                   smp.fall[`TMC_PIN_IRQ_ZERO]);
  assign irq_set_one  = irq_detect(ext_irq_type_one_reg,
                                   smp.level[`TMC_PIN_IRQ_ONE],
                                   smp.fall[`TMC_PIN_IRQ_ONE]);

  // Timer control register; hardware set wins over any clear
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      ovf_flag_one_reg      <= 1'b0;
      ovf_flag_zero_reg     <= 1'b0;
      ext_irq_flag_one_reg  <= 1'b0;
      ext_irq_flag_zero_reg <= 1'b0;
    end else begin
      ovf_flag_one_reg <= I_T1_OVF ||
        (wr_timer_control ? I_SFR_WDATA[`TMC_TC_OVF_ONE]
                 : ovf_flag_one_reg && !I_ACK_OVF_ONE);
      ovf_flag_zero_reg <= I_T0_OVF ||
        (wr_timer_control ? I_SFR_WDATA[`TMC_TC_OVF_ZERO]
                 : ovf_flag_zero_reg && !I_ACK_OVF_ZERO);
      ext_irq_flag_one_reg <= irq_set_one ||
        (wr_timer_control ? I_SFR_WDATA[`TMC_TC_IRQ_FLAG_ONE]
                 : ext_irq_flag_one_reg && !I_ACK_IRQ_ONE);
      ext_irq_flag_zero_reg <= irq_set_zero ||
        (wr_timer_control ? I_SFR_WDATA[`TMC_TC_IRQ_FLAG_ZERO]
                 : ext_irq_flag_zero_reg && !I_ACK_IRQ_ZERO);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      run_bit_one_reg       <= 1'b0;
      run_bit_zero_reg      <= 1'b0;
      ext_irq_type_one_reg  <= 1'b0;
      ext_irq_type_zero_reg <= 1'b0;
    end else if (wr_timer_control) begin
      run_bit_one_reg       <= I_SFR_WDATA[`TMC_TC_RUN_ONE];
      run_bit_zero_reg      <= I_SFR_WDATA[`TMC_TC_RUN_ZERO];
      ext_irq_type_one_reg  <= I_SFR_WDATA[`TMC_TC_IRQ_TYPE_ONE];
      ext_irq_type_zero_reg <= I_SFR_WDATA[`TMC_TC_IRQ_TYPE_ZERO];
    end
  end

  // Third timer control bits written by software
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      receive_clock_select_reg    <= 1'b0;
      transmit_clock_select_reg   <= 1'b0;
      external_trigger_enable_reg <= 1'b0;
      third_run_bit_reg           <= 1'b0;
      count_source_select_reg     <= 1'b0;
      capture_reload_select_reg   <= 1'b0;
    end else if (wr_third_timer_control) begin
      receive_clock_select_reg    <= I_SFR_WDATA[`TMC_T2_RX_CLK];
      transmit_clock_select_reg   <= I_SFR_WDATA[`TMC_T2_TX_CLK];
      external_trigger_enable_reg <= I_SFR_WDATA[`TMC_T2_EXT_EN];
      third_run_bit_reg           <= I_SFR_WDATA[`TMC_T2_RUN];
      count_source_select_reg     <= I_SFR_WDATA[`TMC_T2_SRC];
      capture_reload_select_reg   <= I_SFR_WDATA[`TMC_T2_CAP_RLD];
    end
  end

  // Count source: event pin, or oscillator/12, or oscillator/2 when baud
  always_comb begin
    if (count_source_select_reg) begin
      count_tick = smp.fall[`TMC_PIN_EVENT];
    end else if (mode == TMC_MODE_BAUD) begin
      count_tick = smp.tick_half;
    end else begin
      count_tick = smp.tick_mc;
    end
  end

  assign overflow = (mode != TMC_MODE_OFF) && count_tick &&
                    (count_reg == 16'hffff);
  assign trigger_event = (mode != TMC_MODE_OFF) &&
                         external_trigger_enable_reg &&
                         smp.fall[`TMC_PIN_TRIGGER];
  assign third_baud_pulse = overflow && (mode == TMC_MODE_BAUD);

  // Software write wins over counting in the same cycle
  always_comb begin
    count_next = count_reg;
    case (mode)
      TMC_MODE_OFF: begin
        count_next = count_reg;
      end
      TMC_MODE_CAPTURE: begin
        if (count_tick) begin
          count_next = count_reg + 16'h0001;
        end
      end
      TMC_MODE_RELOAD: begin
        if (trigger_event || overflow) begin
          count_next = capture_reload_reg;
        end else if (count_tick) begin
          count_next = count_reg + 16'h0001;
        end
      end
      TMC_MODE_BAUD: begin
        if (overflow) begin
          count_next = capture_reload_reg;
        end else if (count_tick) begin
          count_next = count_reg + 16'h0001;
        end
      end
      default: begin
        count_next = count_reg;
      end
    endcase
    if (wr_low) begin
      count_next[7:0] = I_SFR_WDATA;
    end
    if (wr_high) begin
      count_next[15:8] = I_SFR_WDATA;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      count_reg <= `TMC_RST_COUNT;
    end else begin
      count_reg <= count_next;
    end
  end

  // Capture pair: software preset or capture of the running count
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      capture_reload_reg <= `TMC_RST_COUNT;
    end else if (trigger_event && (mode == TMC_MODE_CAPTURE)) begin
      capture_reload_reg <= count_reg;
    end else begin
      if (wr_cap_low) begin
        capture_reload_reg[7:0] <= I_SFR_WDATA;
      end
      if (wr_cap_high) begin
        capture_reload_reg[15:8] <= I_SFR_WDATA;
      end
    end
  end

  // Third timer flags; software clears them, hardware set wins
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      third_overflow_flag_reg <= 1'b0;
      third_external_flag_reg <= 1'b0;
    end else begin
      third_overflow_flag_reg <=
        (overflow && (mode != TMC_MODE_BAUD)) ||
        (wr_third_timer_control ? I_SFR_WDATA[`TMC_T2_OVF]
                  : third_overflow_flag_reg);
      third_external_flag_reg <= trigger_event ||
        (wr_third_timer_control ? I_SFR_WDATA[`TMC_T2_EXT]
                  : third_external_flag_reg);
    end
  end

  // Registered read data, one cycle after the address
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      rdata_reg <= 8'h00;
    end else begin
      case (I_SFR_ADDR)
        `TMC_ADDR_TIMER_CONTROL: begin
          rdata_reg <= {ovf_flag_one_reg, run_bit_one_reg,
                        ovf_flag_zero_reg, run_bit_zero_reg,
                        ext_irq_flag_one_reg, ext_irq_type_one_reg,
                        ext_irq_flag_zero_reg, ext_irq_type_zero_reg};
        end
        `TMC_ADDR_THIRD_CONTROL: begin
          rdata_reg <= {third_overflow_flag_reg, third_external_flag_reg,
                        receive_clock_select_reg,
                        transmit_clock_select_reg,
                        external_trigger_enable_reg, third_run_bit_reg,
                        count_source_select_reg,
                        capture_reload_select_reg};
        end
        `TMC_ADDR_COUNT_LOW: begin
          rdata_reg <= count_reg[7:0];
        end
        `TMC_ADDR_COUNT_HIGH: begin
          rdata_reg <= count_reg[15:8];
        end
        `TMC_ADDR_CAPRLD_LOW: begin
          rdata_reg <= capture_reload_reg[7:0];
        end
        `TMC_ADDR_CAPRLD_HIGH: begin
          rdata_reg <= capture_reload_reg[15:8];
        end
        default: begin
          rdata_reg <= 8'h00;
        end
      endcase
    end
  end

  assign O_SFR_RDATA     = rdata_reg;
  assign O_OVF_FLAG_ZERO = ovf_flag_zero_reg;
  assign O_OVF_FLAG_ONE  = ovf_flag_one_reg;
  assign O_IRQ_FLAG_ZERO = ext_irq_flag_zero_reg;
  assign O_IRQ_FLAG_ONE  = ext_irq_flag_one_reg;
  assign O_THIRD_IRQ     = third_overflow_flag_reg ||
                           third_external_flag_reg;

  // Serial port divides these pulses by 16 itself
  assign O_RX_BAUD_PULSE = receive_clock_select_reg ? third_baud_pulse
                                                    : I_T1_OVF;
  assign O_TX_BAUD_PULSE = transmit_clock_select_reg ? third_baud_pulse
                                                     : I_T1_OVF;

endmodule

`default_nettype wire

// ---- src/tmc_cfg.svh ----
/*
  Address, field and timing constants of the timer control block.
  Assumes one oscillator clock and a byte-wide special function bus.
*/
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// Special function register addresses
`define TMC_ADDR_TIMER_CONTROL  8'h88
`define TMC_ADDR_THIRD_CONTROL  8'hc8
`define TMC_ADDR_COUNT_LOW      8'hcc
`define TMC_ADDR_COUNT_HIGH     8'hcd
`define TMC_ADDR_CAPRLD_LOW     8'hca
`define TMC_ADDR_CAPRLD_HIGH    8'hcb

// Reset values
`define TMC_RST_TIMER_CONTROL   8'h00
`define TMC_RST_THIRD_CONTROL   8'h00
`define TMC_RST_COUNT           16'h0000

// Timer control field positions
`define TMC_TC_OVF_ONE          7
`define TMC_TC_RUN_ONE          6
`define TMC_TC_OVF_ZERO         5
`define TMC_TC_RUN_ZERO         4
`define TMC_TC_IRQ_FLAG_ONE     3
`define TMC_TC_IRQ_TYPE_ONE     2
`define TMC_TC_IRQ_FLAG_ZERO    1
`define TMC_TC_IRQ_TYPE_ZERO    0

// Third timer control field positions
`define TMC_T2_OVF              7
`define TMC_T2_EXT              6
`define TMC_T2_RX_CLK           5
`define TMC_T2_TX_CLK           4
`define TMC_T2_EXT_EN           3
`define TMC_T2_RUN              2
`define TMC_T2_SRC              1
`define TMC_T2_CAP_RLD          0

// Timing: oscillator periods per machine cycle and per baud count
`define TMC_OSC_PER_MACHINE     12
`define TMC_OSC_PER_BAUD_TICK   2
`define TMC_PRESCALE_MAX        4'd11

// Sampled pin indices
`define TMC_PIN_EVENT           0
`define TMC_PIN_TRIGGER         1
`define TMC_PIN_IRQ_ZERO        2
`define TMC_PIN_IRQ_ONE         3
`define TMC_NUM_PINS            4

`endif

// ---- src/tmc_pkg.sv ----
/*
  Types shared by the timer control block.
  Assumes tmc_cfg.svh supplies the numeric constants.
*/
package tmc_pkg;

  typedef enum logic [1:0] {
    TMC_MODE_OFF     = 2'b00,
    TMC_MODE_RELOAD  = 2'b01,
    TMC_MODE_CAPTURE = 2'b10,
    TMC_MODE_BAUD    = 2'b11
  } tmc_mode_type;

endpackage

// ---- src/tmc_smp_if.sv ----
/*
  Carrier between the pin sampler and the timer control logic.
  Assumes both ends run on the same oscillator clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

interface tmc_smp_if;
  logic                       tick_mc;
  logic                       tick_half;
  logic [`TMC_NUM_PINS-1:0]   level;
  logic [`TMC_NUM_PINS-1:0]   fall;

  modport sampler (
    output tick_mc,
    output tick_half,
    output level,
    output fall
  );

  modport user (
    input  tick_mc,
    input  tick_half,
    input  level,
    input  fall
  );
endinterface

`default_nettype wire

// ---- src/tmc_pin_sampler.sv ----
/*
  Machine cycle timing and per-machine-cycle sampling of external pins.
  Assumes pins are asynchronous to the oscillator clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_pin_sampler #(
  parameter int NUM_PINS = `TMC_NUM_PINS
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rstn,
  // Raw pins
  input  wire logic [NUM_PINS-1:0] i_pins,
  // Sampled view
  tmc_smp_if.sampler               smp
);

  logic [3:0]          prescale_reg;
  logic                half_reg;
  logic [NUM_PINS-1:0] sync1_reg;
  logic [NUM_PINS-1:0] sync2_reg;
  logic [NUM_PINS-1:0] sample_reg;
  logic [NUM_PINS-1:0] fall_reg;
  logic                tick_mc;

  assign tick_mc = (prescale_reg == `TMC_PRESCALE_MAX);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      prescale_reg <= 4'h0;
    end else if (tick_mc) begin
      prescale_reg <= 4'h0;
    end else begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end

  // Baud timing counts every second oscillator period
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= i_pins;
      sync2_reg <= sync1_reg;
    end
  end

  // Pins are sampled once per machine cycle; a shorter level can be missed
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          sample_reg[g] <= 1'b1;
          fall_reg[g]   <= 1'b0;
        end else if (tick_mc) begin
          sample_reg[g] <= sync2_reg[g];
          fall_reg[g]   <= sample_reg[g] & ~sync2_reg[g];
        end else begin
          fall_reg[g]   <= 1'b0;
        end
      end
    end
  endgenerate

  assign smp.tick_mc   = tick_mc;
  assign smp.tick_half = half_reg;
  assign smp.level     = sample_reg;
  assign smp.fall      = fall_reg;

endmodule

`default_nettype wire

// ---- tb/tmc_timer_ctrl_checker.sv ----
/*
  Port-level assertions for the timer control block.
  Assumes it is bound to tmc_timer_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_chk (
  // Clock, reset and register bus
  input wire logic       I_CLK,
  input wire logic       I_RSTN,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic       I_SFR_WR,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic [7:0] O_SFR_RDATA,
  // Acknowledges and basic timer links
  input wire logic       I_ACK_OVF_ONE,
  input wire logic       I_ACK_IRQ_ZERO,
  input wire logic       I_T0_OVF,
  input wire logic       I_T1_OVF,
  input wire logic       O_T0_COUNT_EN,
  input wire logic       O_T1_COUNT_EN,
  // Flags and baud pulses
  input wire logic       O_OVF_FLAG_ZERO,
  input wire logic       O_OVF_FLAG_ONE,
  input wire logic       O_IRQ_FLAG_ZERO,
  input wire logic       O_THIRD_IRQ,
  input wire logic       O_RX_BAUD_PULSE,
  input wire logic       O_TX_BAUD_PULSE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  // Software writes may set or clear flags, so they mask the hold checks
  logic wr_tc;
  logic wr_t2;
  assign wr_tc = I_SFR_WR && I_SFR_ADDR == 8'h88;
  assign wr_t2 = I_SFR_WR && I_SFR_ADDR == 8'hc8;

  a_ovf_one_set: assert property (I_T1_OVF |=> O_OVF_FLAG_ONE)
    else $error("overflow flag one not set");
  a_ovf_zero_set: assert property (I_T0_OVF |-> ##1 O_OVF_FLAG_ZERO)
    else $error("overflow flag zero not set");
  a_ovf_ack_clear: assert property (
    (I_ACK_OVF_ONE && !I_T1_OVF && !wr_tc) |=> !O_OVF_FLAG_ONE)
    else $error("overflow flag one not cleared by service");
  a_run_zero_stop: assert property (
    (wr_tc && !I_SFR_WDATA[4]) |=> !O_T0_COUNT_EN)
    else $error("timer zero enabled with run bit clear");
  a_run_one_stop: assert property (
    (wr_tc && !I_SFR_WDATA[6]) |=> (!O_T1_COUNT_EN)[*2])
    else $error("timer one enabled with run bit clear");
  a_irq_flag_hold: assert property (
    (O_IRQ_FLAG_ZERO && !I_ACK_IRQ_ZERO && !wr_tc) |=> O_IRQ_FLAG_ZERO)
    else $error("interrupt flag zero dropped without service");
  a_third_irq_hold: assert property (
    (O_THIRD_IRQ && !wr_t2) |=> O_THIRD_IRQ)
    else $error("third timer request dropped without software");
  a_third_irq_or: assert property (
    ($past(I_SFR_ADDR) == 8'hc8)
    |-> ($past(O_THIRD_IRQ) == |O_SFR_RDATA[7:6]))
    else $error("third timer request differs from its flags");
  a_rx_route_t1: assert property (
    ($past(I_SFR_ADDR) == 8'hc8 && !O_SFR_RDATA[5])
    |-> $past(O_RX_BAUD_PULSE) == $past(I_T1_OVF))
    else $error("receive clock not from timer one");
  a_tx_route_t1: assert property (
    ($past(I_SFR_ADDR) == 8'hc8 && !O_SFR_RDATA[4])
    |-> $past(O_TX_BAUD_PULSE) == $past(I_T1_OVF))
    else $error("transmit clock not from timer one");
endmodule

bind tmc_timer_ctrl tmc_chk u_chk (.*);

`default_nettype wire

// ---- tb/tmc_pin_partner.sv ----
/*
  Model of the outside world driving the four timer pins.
  Assumes the bench asks for levels; pins change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_pin_partner (
  // Clock and requested levels
  input  wire logic       i_clk,
  input  wire logic [3:0] i_want,
  // Driven pins
  output logic      [3:0] o_pins
);
  int hold;

  initial begin
    o_pins = 4'hf;
    hold = 0;
  end

  // Two machine cycles per level so a sample can never miss it
  always @(negedge i_clk) begin
    if (hold != 0) begin
      hold <= hold - 1;
    end else if (o_pins != i_want) begin
      o_pins <= i_want;
      hold <= 24;
    end
  end
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
/*
  Self-checking bench for the timer control block.
  Assumes tmc_timer_ctrl, its checker and the pin partner are compiled.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       I_CLK, I_RSTN, I_SFR_WR, I_GATE_ZERO, I_GATE_ONE;
  logic       I_ACK_OVF_ONE, I_ACK_OVF_ZERO, I_ACK_IRQ_ONE, I_ACK_IRQ_ZERO;
  logic       I_T0_OVF, I_T1_OVF, O_T0_COUNT_EN, O_T1_COUNT_EN;
  logic [7:0] I_SFR_ADDR, I_SFR_WDATA, O_SFR_RDATA;
  logic       O_OVF_FLAG_ZERO, O_OVF_FLAG_ONE, O_IRQ_FLAG_ZERO;
  logic       O_IRQ_FLAG_ONE, O_THIRD_IRQ, O_RX_BAUD_PULSE, O_TX_BAUD_PULSE;
  logic [3:0] want;
  wire  [3:0] pins;
  wire        I_EVENT_PIN, I_TRIGGER_PIN, I_IRQ_PIN_ZERO, I_IRQ_PIN_ONE;
  int         fail_count, n_tests, nrx, ntx;

  assign {I_IRQ_PIN_ONE, I_IRQ_PIN_ZERO, I_TRIGGER_PIN, I_EVENT_PIN} = pins;

`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end

  tmc_timer_ctrl dut (.*);
  tmc_pin_partner u_pins (.i_clk(I_CLK), .i_want(want), .o_pins(pins));

  initial begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge I_CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge I_CLK);
    I_SFR_ADDR = a;
    I_SFR_WDATA = v;
    I_SFR_WR = 1'b1;
    @(negedge I_CLK);
    I_SFR_WR = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge I_CLK);
    I_SFR_ADDR = a;
    @(negedge I_CLK);
    `CHK($sformatf("sfr %h", a), e, O_SFR_RDATA)
  endtask

  task automatic pin(input logic [3:0] w, input int n);
    want = w;
    cyc(n);
  endtask

  // Bounded, so a missing request shows up as a bad read afterwards
  task automatic wait_irq;
    for (int i = 0; i < 200 && O_THIRD_IRQ !== 1'b1; i++) @(negedge I_CLK);
  endtask

  task automatic results;
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {I_RSTN, I_SFR_WR, I_GATE_ZERO, I_GATE_ONE, I_T0_OVF, I_T1_OVF} = '0;
    {I_ACK_OVF_ONE, I_ACK_OVF_ZERO, I_ACK_IRQ_ONE, I_ACK_IRQ_ZERO} = '0;
    I_SFR_ADDR = 8'h00;
    I_SFR_WDATA = 8'h00;
    want = 4'hf;
    fail_count = 0;
    n_tests = 0;
    cyc(6);
    I_RSTN = 1'b1;
    rd(8'h88, 8'h00);
    rd(8'hc8, 8'h00);
    rd(8'hcd, 8'h00);
    rd(8'h42, 8'h00);
    wr(8'h88, 8'h50);
    cyc(1);
    `CHK("t0 en", 1'b1, O_T0_COUNT_EN)
    `CHK("t1 en", 1'b1, O_T1_COUNT_EN)
    I_GATE_ZERO = 1'b1;
    I_GATE_ONE = 1'b1;
    pin(4'hb, 60);
    `CHK("gated", 1'b0, O_T0_COUNT_EN)
    `CHK("gate one", 1'b1, O_T1_COUNT_EN)
    `CHK("level", 1'b1, O_IRQ_FLAG_ZERO)
    I_ACK_IRQ_ZERO = 1'b1;
    cyc(1);
    I_ACK_IRQ_ZERO = 1'b0;
    cyc(2);
    `CHK("relevel", 1'b1, O_IRQ_FLAG_ZERO)
    pin(4'hf, 60);
    `CHK("ungated", 1'b1, O_T0_COUNT_EN)
    {I_ACK_IRQ_ZERO, I_T0_OVF, I_T1_OVF} = 3'h7;
    cyc(1);
    {I_ACK_IRQ_ZERO, I_T0_OVF, I_T1_OVF} = 3'h0;
    rd(8'h88, 8'hf0);
    {I_ACK_OVF_ONE, I_ACK_OVF_ZERO} = 2'h3;
    cyc(1);
    {I_ACK_OVF_ONE, I_ACK_OVF_ZERO} = 2'h0;
    rd(8'h88, 8'h50);
    wr(8'h88, 8'h05);
    pin(4'h7, 60);
    `CHK("edge", 1'b1, O_IRQ_FLAG_ONE)
    I_ACK_IRQ_ONE = 1'b1;
    cyc(1);
    I_ACK_IRQ_ONE = 1'b0;
    pin(4'hf, 30);
    `CHK("edge once", 1'b0, O_IRQ_FLAG_ONE)
    // Auto-reload by overflow, then by trigger edge
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfd);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    wait_irq;
    rd(8'hcc, 8'hfe);
    rd(8'hc8, 8'h84);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h0c);
    pin(4'hd, 0);
    wait_irq;
    rd(8'hcd, 8'hff);
    rd(8'hc8, 8'h4c);
    pin(4'hf, 30);
    // Capture on a frozen event count, first with the trigger disabled
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'h34);
    wr(8'hcd, 8'h12);
    wr(8'hc8, 8'h07);
    pin(4'hd, 60);
    `CHK("no trig", 1'b0, O_THIRD_IRQ)
    pin(4'hf, 30);
    wr(8'hc8, 8'h0f);
    pin(4'hd, 0);
    wait_irq;
    rd(8'hca, 8'h34);
    rd(8'hcb, 8'h12);
    rd(8'hc8, 8'h4f);
    pin(4'hc, 60);
    rd(8'hcc, 8'h35);
    wr(8'hc8, 8'h0b);
    pin(4'hd, 60);
    pin(4'hc, 60);
    rd(8'hcc, 8'h35);
    // Baud mode: reload of fffc every 4 ticks of 2 clocks
    wr(8'hca, 8'hfc);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfc);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h34);
    nrx = 0;
    ntx = 0;
    repeat (80) begin
      @(negedge I_CLK);
      nrx += O_RX_BAUD_PULSE;
      ntx += O_TX_BAUD_PULSE;
    end
    `CHK("rx rate", 10, nrx)
    `CHK("tx rate", 10, ntx)
    rd(8'hc8, 8'h34);
    // Trigger has been low since the capture test; raise it first
    pin(4'he, 30);
    wr(8'hc8, 8'h3c);
    pin(4'hc, 0);
    wait_irq;
    rd(8'hc8, 8'h7c);
    wr(8'hc8, 8'h14);
    @(negedge I_CLK);
    I_T1_OVF = 1'b1;
    #1;
    `CHK("rx t1", 1'b1, O_RX_BAUD_PULSE)
    @(negedge I_CLK);
    I_T1_OVF = 1'b0;
    results();
  end

  initial begin
    #(25 * 20000);
    fail_count++;
    results();
  end
endmodule

`default_nettype wire
